// ---- bench/atrc_core_tb.sv ----
// Self-checking bench for the asynchronous timer core
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module atrc_core_tb;
  import atrc_pkg::*;
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest, debugHalt, runInDebug, periphDebug;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, c0;
  logic [3:0] srcPin;
  atrc_irq_t irq;
  int errors = 0;
  int comparisons = 0;
  int n;

  always #10 core_clk = ~core_clk;

  atrc_src_model src (.srcPin(srcPin));

  atrc_core dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .srcPin(srcPin), .debugHalt(debugHalt),
    .runInDebug(runInDebug), .periphDebug(periphDebug), .irq(irq));

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Request stands until waitrequest is sampled low; data taken at that edge only
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_write <= wr;
    avs_read <= ~wr;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge core_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  // Synced writes are dropped while busy, so this follows each one before the next, except in the drop test and after the wrap test's control write
  task automatic idle;
    do
    begin
      rd(OFF_STATUS);
    end
    while ((q[ST_BUSY] | q[ST_CLK_BUSY]) !== 1'b0);
    // Ready flags land one cycle after busy falls, so look once more
    rd(OFF_STATUS);
  endtask

  task automatic waitbit(input logic [7:0] a, input logic [31:0] m);
    int k;
    k = 0;
    do
    begin
      rd(a);
      k++;
    end
    while ((q & m) === 32'h0 && k < 400);
  endtask

  function automatic logic [31:0] cal(input int y, input int mo, input int d, input int h, input int mi,
    input int s);
    cal = {y[5:0], mo[3:0], d[4:0], h[4:0], mi[5:0], s[5:0]};
  endfunction

  initial
  begin
    #1_500_000;
    $display("ERROR watchdog expected done seen hang");
    errors++;
    close_out();
  end

  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    debugHalt = 1'b0;
    runInDebug = 1'b0;
    periphDebug = 1'b0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    wr(8'h3c, 32'hffff_ffff);
    rd(OFF_CONTROL);
    `CHK("control reset", 32'h0, q)
    rd(OFF_COUNT);
    `CHK("count reset", 32'h0, q)
    rd(OFF_IRQ_MASK);
    `CHK("mask reset", 32'h0, q)
    rd(8'h3c);
    `CHK("unmapped", 32'h0, q)
    $display("test reset done");

    wr(OFF_CLOCK, 32'h0000_0200);
    rd(OFF_STATUS);
    `CHK("clock busy", 1'b1, q[ST_CLK_BUSY])
    idle();
    `CHK("clock ready", 1'b1, q[ST_CLK_READY])
    wr(OFF_IRQ_EN, 32'h2000_0000);
    wr(OFF_IRQ_EN, 32'h0);
    rd(OFF_IRQ_MASK);
    `CHK("mask set", 32'h2000_0000, q)
    repeat (2) @(posedge core_clk);
    `CHK("clock_sync_done_irq irq", 1'b1, irq.clock_sync_done_irq)
    wr(OFF_STAT_CLEAR, 32'h2000_0000);
    idle();
    `CHK("ready flag", 1'b1, q[ST_READY])
    `CHK("clock_sync_done_irq cleared", 1'b0, irq.clock_sync_done_irq)
    wr(OFF_IRQ_EN, 32'h0200_0000);
    repeat (2) @(posedge core_clk);
    `CHK("ready irq", 1'b1, irq.ready)
    wr(OFF_IRQ_DIS, 32'h0200_0000);
    wr(OFF_CLOCK, 32'h0000_0201);
    idle();
    wr(OFF_IRQ_DIS, 32'h2000_0000);
    rd(OFF_IRQ_MASK);
    `CHK("mask cleared", 32'h0, q)
    repeat (2) @(posedge core_clk);
    `CHK("clock_sync_done_irq masked", 1'b0, irq.clock_sync_done_irq)
    $display("test clock done");

    wr(OFF_COUNT, 32'hffff_fff0);
    rd(OFF_COUNT);
    `CHK("read while busy", 32'h0, q)
    idle();
    rd(OFF_COUNT);
    `CHK("count written", 32'hffff_fff0, q)
    wr(OFF_COUNT, 32'hffff_fff0);
    wr(OFF_COUNT, 32'h0000_0000);
    idle();
    rd(OFF_COUNT);
    `CHK("write dropped while busy", 32'hffff_fff0, q)
    wr(OFF_STAT_CLEAR, 32'hffff_ffff);
    idle();
    `CHK("wrap clear", 1'b0, q[ST_WRAP])
    wr(OFF_CONTROL, 32'h0000_0001);
    waitbit(OFF_STATUS, 32'h0000_0001);
    `CHK("wrap flag", 1'b1, q[ST_WRAP])
    rd(OFF_COUNT);
    `CHK("wrapped count", 24'h0, q[31:8])
    wr(OFF_IRQ_EN, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    `CHK("wrap irq", 1'b1, irq.wrap)
    wr(OFF_IRQ_DIS, 32'h0000_0001);
    wr(OFF_PERIOD0, 32'h0);
    idle();
    wr(OFF_STAT_CLEAR, 32'h0001_0000);
    idle();
    waitbit(OFF_STATUS, 32'h0001_0000);
    `CHK("period flag", 1'b1, q[ST_PERIOD_LSB])
    wr(OFF_IRQ_EN, 32'h0001_0000);
    repeat (2) @(posedge core_clk);
    `CHK("period irq", 1'b1, irq.period)
    wr(OFF_IRQ_DIS, 32'h0001_0000);
    $display("test counter done");

    wr(OFF_CONTROL, 32'h0);
    idle();
    wr(OFF_COUNT, 32'h0);
    idle();
    wr(OFF_ALARM_MATCH_FLAG_0, 32'h0000_0040);
    idle();
    wr(OFF_STAT_CLEAR, 32'h0000_0101);
    idle();
    wr(OFF_CONTROL, 32'h0000_0101);
    idle();
    waitbit(OFF_STATUS, 32'h0000_0100);
    `CHK("alarm flag", 1'b1, q[ST_ALARM_LSB])
    waitbit(OFF_STATUS, 32'h0000_0001);
    `CHK("alarm wrap", 1'b1, q[ST_WRAP])
    rd(OFF_COUNT);
    `CHK("alarm cleared count", 1'b1, q < 32'h0000_0040)
    wr(OFF_IRQ_EN, 32'h0000_0100);
    repeat (2) @(posedge core_clk);
    `CHK("alarm irq", 1'b1, irq.alarm)
    $display("test alarm done");

    // Tap three on the bus source: one count per 16 cycles, reads 163 cycles apart
    wr(OFF_CONTROL, 32'h0003_0003);
    idle();
    rd(OFF_COUNT);
    c0 = q;
    repeat (160) @(posedge core_clk);
    rd(OFF_COUNT);
    `CHK("tap three rate", 1'b1, (q - c0) >= 32'h0000_000a && (q - c0) <= 32'h0000_000b)
    $display("test tap done");

    wr(OFF_CONTROL, 32'h0000_0001);
    idle();
    @(posedge core_clk);
    debugHalt <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(OFF_COUNT);
    c0 = q;
    repeat (50) @(posedge core_clk);
    rd(OFF_COUNT);
    `CHK("frozen in debug", c0, q)
    runInDebug <= 1'b1;
    periphDebug <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(OFF_COUNT);
    c0 = q;
    repeat (50) @(posedge core_clk);
    rd(OFF_COUNT);
    `CHK("runs in debug", 1'b1, q != c0)
    debugHalt <= 1'b0;
    $display("test debug done");

    // Source change: disable, switch, enable, each waited out
    wr(OFF_CONTROL, 32'h0);
    idle();
    wr(OFF_CLOCK, 32'h0000_0200);
    idle();
    wr(OFF_CLOCK, 32'h0000_0100);
    idle();
    wr(OFF_CLOCK, 32'h0000_0101);
    idle();
    for (int y = 4; y < 6; y++)
    begin
      wr(OFF_COUNT, cal(y, 2, 28, 23, 59, 59));
      idle();
      wr(OFF_CONTROL, 32'h0000_0005);
      idle();
      n = 0;
      do
      begin
        rd(OFF_COUNT);
        n++;
      end
      while (q === cal(y, 2, 28, 23, 59, 59) && n < 300);
      `CHK("calendar step", (y == 4) ? cal(4, 2, 29, 0, 0, 0) : cal(5, 3, 1, 0, 0, 0), q)
      wr(OFF_CONTROL, 32'h0);
      idle();
    end
    $display("test calendar done");
    close_out();
  end
endmodule

// ---- bench/atrc_src_model.sv ----
// Free-running oscillator models that feed the timer's source pins
`timescale 1ns/1ps
module atrc_src_model
(
  output logic [3:0] srcPin
);
  // Odd half periods put only every tenth pin edge on a core_clk edge; all well under 1/6 of core_clk
  logic rcOsc = 1'b0;
  logic xtalOsc = 1'b0;
  logic genClk = 1'b0;
  logic khzClk = 1'b0;
  always #311 rcOsc = ~rcOsc;
  always #503 xtalOsc = ~xtalOsc;
  always #417 genClk = ~genClk;
  always #1013 khzClk = ~khzClk;
  assign srcPin = {khzClk, genClk, xtalOsc, rcOsc};
endmodule

// ---- core/atrc_core.sv ----
// Asynchronous timer with prescaler, counter/calendar and Avalon-MM registers
// How it works
// - Enabled prescaler counts selected source edges
// - Prescaler hidden; control write with clear bit clears it
// - Tap field picks prescaler bit for ticks
// - Counter steps on each tap rising edge
// - Counter mode wraps to zero, sets wrap
// - Clear-on-alarm zeroes counter and sets wrap
// - Count register readable and writable
// - Fast reads may skip values; software copes
// - Calendar bit selects calendar counting
// - Calendar keeps time, day, month, year
// - Year offsets divisible by four leap
// - Interrupts same in both modes, except overflow wrap (counter mode only)
// - Five separate interrupt request outputs
// - Wrap on counter-mode overflow or alarm clear
// - Clock ready on clock-busy fall
// - Ready on busy fall
// - Enable/disable words set/clear mask bits
// - Request masked, held until status cleared
// - Clock busy set on clock change
// - Debug halt freezes unless both run bits
// - Periodic flag on chosen prescaler bit rise
// - Alarm flag when count equals alarm
// - While busy, synced writes dropped, reads zero
`timescale 1ns/1ps
module atrc_core
  import atrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] srcPin,
  input wire logic debugHalt,
  input wire logic runInDebug,
  input wire logic periphDebug,
  output atrc_irq_t irq
);

  logic [3:0] pinS1, pinS2, pinS3, pinLvl, pinEdge;
  logic [31:0] pre, next_pre, count, next_count;
  logic [31:0] ctl, alarmVal [2];
  logic [TAP_W-1:0] perTap [2];
  logic clkOn;
  logic [SRC_W-1:0] clkSrc;
  logic [3:0] syncCnt, clkCnt;
  logic busy, clock_sync_pending_bit, busyPrev, clkBusyPrev;
  atrc_flags_t flags, mask, events, clrMask;
  logic wrAcc, syncHit, wrSync, wrClock, srcTick, freeze, run, tick, clrAlarm;
  logic [1:0] alarmEq, alarmEv, perEv;
  logic [31:0] statusWord, readWord;

  // Each source pin passes three flops; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          pinS1[gi] <= 1'b0;
          pinS2[gi] <= 1'b0;
          pinS3[gi] <= 1'b0;
          pinLvl[gi] <= 1'b0;
        end
        else
        begin
          pinS1[gi] <= srcPin[gi];
          pinS2[gi] <= pinS1[gi];
          pinS3[gi] <= pinS2[gi];
          if (pinS2[gi] == pinS3[gi])
            pinLvl[gi] <= pinS3[gi];
        end
      end
      assign pinEdge[gi] = (pinS2[gi] == pinS3[gi]) && pinS3[gi] && !pinLvl[gi];
    end
  endgenerate

  // Source select; the bus clock source ticks every cycle
  always_comb
  begin
    case (clkSrc)
      SRC_RC: srcTick = pinEdge[0];
      SRC_XTAL: srcTick = pinEdge[1];
      SRC_BUS: srcTick = 1'b1;
      SRC_GEN: srcTick = pinEdge[2];
      SRC_KHZ: srcTick = pinEdge[3];
      default: srcTick = 1'b0;
    endcase
  end

  assign freeze = debugHalt && !(runInDebug && periphDebug);
  assign run = ctl[CTL_RUN_BIT] && clkOn && !freeze && srcTick;
  assign next_pre = pre + 32'h0000_0001;
  assign tick = run && !pre[ctl[CTL_TAP_LSB +: TAP_W]] && next_pre[ctl[CTL_TAP_LSB +: TAP_W]];

  // Bus handshake: one wait state, then the request is taken
  assign wrAcc = avs_write && !avs_waitrequest;
  assign syncHit = (avs_address == OFF_CONTROL) || (avs_address == OFF_COUNT) ||
                   (avs_address == OFF_STAT_CLEAR) || (avs_address == OFF_ALARM_MATCH_FLAG_0) ||
                   (avs_address == OFF_ALARM_MATCH_FLAG_1) || (avs_address == OFF_PERIOD0) ||
                   (avs_address == OFF_PERIOD1);
  assign wrSync = wrAcc && syncHit && !busy;
  assign wrClock = wrAcc && (avs_address == OFF_CLOCK) && !clock_sync_pending_bit;
  assign busy = syncCnt != 4'h0;
  assign clock_sync_pending_bit = clkCnt != 4'h0;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else if ((avs_read || avs_write) && avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // Prescaler; a clear request beats counting
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pre <= WORD_RESET;
    else if (wrSync && avs_address == OFF_CONTROL && avs_writedata[CTL_PRE_CLEAR_BIT])
      pre <= WORD_RESET;
    else if (run)
      pre <= next_pre;
  end

  // Control word; the prescaler clear bit is a strobe and is not stored
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctl <= WORD_RESET;
    else if (wrSync && avs_address == OFF_CONTROL)
    begin
      ctl <= avs_writedata;
      ctl[CTL_PRE_CLEAR_BIT] <= 1'b0;
    end
  end

  // Alarm values and periodic taps
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          alarmVal[gi] <= WORD_RESET;
          perTap[gi] <= '0;
        end
        else if (wrSync)
        begin
          if (avs_address == (gi == 0 ? OFF_ALARM_MATCH_FLAG_0 : OFF_ALARM_MATCH_FLAG_1))
            alarmVal[gi] <= avs_writedata;
          if (avs_address == (gi == 0 ? OFF_PERIOD0 : OFF_PERIOD1))
            perTap[gi] <= avs_writedata[TAP_W-1:0];
        end
      end
      assign alarmEq[gi] = count == alarmVal[gi];
      assign alarmEv[gi] = tick && (next_count == alarmVal[gi]);
      assign perEv[gi] = run && !pre[perTap[gi]] && next_pre[perTap[gi]];
    end
  endgenerate

  // Calendar step with month lengths and leap years
  function automatic logic [31:0] calNext(input logic [31:0] v);
    logic [5:0] sec, min, yr;
    logic [4:0] hr, day, last;
    logic [3:0] mon;
    sec = v[CAL_SEC_LSB +: 6];
    min = v[CAL_MIN_LSB +: 6];
    hr = v[CAL_HOUR_LSB +: 5];
    day = v[CAL_DAY_LSB +: 5];
    mon = v[CAL_MON_LSB +: 4];
    yr = v[CAL_YEAR_LSB +: 6];
    case (mon)
      4'h2: last = (yr[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: last = 5'h1e;
      default: last = 5'h1f;
    endcase
    if (sec != 6'h3b)
      sec = sec + 6'h01;
    else
    begin
      sec = 6'h00;
      if (min != 6'h3b)
        min = min + 6'h01;
      else
      begin
        min = 6'h00;
        if (hr != 5'h17)
          hr = hr + 5'h01;
        else
        begin
          hr = 5'h00;
          if (day < last)
            day = day + 5'h01;
          else
          begin
            day = 5'h01;
            if (mon < 4'hc)
              mon = mon + 4'h1;
            else
            begin
              mon = 4'h1;
              yr = yr + 6'h01;
            end
          end
        end
      end
    end
    return {yr, mon, day, hr, min, sec};
  endfunction

  assign clrAlarm = |(alarmEq & ctl[CTL_CLR_ALARM_LSB +: 2]);

  always_comb
  begin
    if (clrAlarm)
      next_count = WORD_RESET;
    else if (ctl[CTL_CAL_BIT])
      next_count = calNext(count);
    else
      next_count = count + 32'h0000_0001;
  end

  // Counter; a software write wins over a tick in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count <= WORD_RESET;
    else if (wrSync && avs_address == OFF_COUNT)
      count <= avs_writedata;
    else if (tick)
      count <= next_count;
  end

  // Write synchronisation busy and clock busy counters
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      syncCnt <= 4'h0;
      busyPrev <= 1'b0;
    end
    else
    begin
      busyPrev <= busy;
      if (wrSync)
        syncCnt <= SYNC_CYCLES;
      else if (busy)
        syncCnt <= syncCnt - 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      clkCnt <= 4'h0;
      clkBusyPrev <= 1'b0;
      clkOn <= 1'b0;
      clkSrc <= SRC_RC;
    end
    else
    begin
      clkBusyPrev <= clock_sync_pending_bit;
      if (wrClock)
      begin
        clkOn <= avs_writedata[CLK_ON_BIT];
        clkSrc <= avs_writedata[CLK_SRC_LSB +: SRC_W];
        if (avs_writedata[CLK_ON_BIT] != clkOn || avs_writedata[CLK_SRC_LSB +: SRC_W] != clkSrc)
          clkCnt <= CLK_SYNC_CYCLES;
      end
      else if (clock_sync_pending_bit)
        clkCnt <= clkCnt - 4'h1;
    end
  end

  // Events and status flags; a new event wins over a clear in the same cycle
  always_comb
  begin
    events.wrap = tick && (clrAlarm || (!ctl[CTL_CAL_BIT] && count == 32'hffff_ffff));
    events.alarm = alarmEv;
    events.period = perEv;
    events.ready = busyPrev && !busy;
    events.clock_sync_done_irq = clkBusyPrev && !clock_sync_pending_bit;
  end

  function automatic atrc_flags_t fromWord(input logic [31:0] w);
    atrc_flags_t f;
    f.wrap = w[ST_WRAP];
    f.alarm = w[ST_ALARM_LSB +: 2];
    f.period = w[ST_PERIOD_LSB +: 2];
    f.ready = w[ST_READY];
    f.clock_sync_done_irq = w[ST_CLK_READY];
    return f;
  endfunction

  function automatic logic [31:0] toWord(input atrc_flags_t f);
    logic [31:0] w;
    w = WORD_RESET;
    w[ST_WRAP] = f.wrap;
    w[ST_ALARM_LSB +: 2] = f.alarm;
    w[ST_PERIOD_LSB +: 2] = f.period;
    w[ST_READY] = f.ready;
    w[ST_CLK_READY] = f.clock_sync_done_irq;
    return w;
  endfunction

  assign clrMask = wrSync && avs_address == OFF_STAT_CLEAR ? fromWord(avs_writedata) : atrc_flags_t'(7'h00);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      flags <= atrc_flags_t'(7'h00);
    else
      flags <= (flags & ~clrMask) | events;
  end

  // Interrupt mask: write-one-to-set and write-one-to-clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      mask <= atrc_flags_t'(7'h00);
    else if (wrAcc && avs_address == OFF_IRQ_EN)
      mask <= mask | fromWord(avs_writedata);
    else if (wrAcc && avs_address == OFF_IRQ_DIS)
      mask <= mask & ~fromWord(avs_writedata);
  end

  // Five request lines, each registered from masked status
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irq <= atrc_irq_t'(5'h00);
    else
    begin
      irq.wrap <= flags.wrap && mask.wrap;
      irq.period <= |(flags.period & mask.period);
      irq.alarm <= |(flags.alarm & mask.alarm);
      irq.clock_sync_done_irq <= flags.clock_sync_done_irq && mask.clock_sync_done_irq;
      irq.ready <= flags.ready && mask.ready;
    end
  end

  // Read mux; synchronised registers read zero while busy
  always_comb
  begin
    statusWord = toWord(flags);
    statusWord[ST_BUSY] = busy;
    statusWord[ST_CLK_BUSY] = clock_sync_pending_bit;
    readWord = WORD_RESET;
    case (avs_address)
      OFF_CONTROL: readWord = ctl;
      OFF_COUNT: readWord = count;
      OFF_STATUS: readWord = statusWord;
      OFF_IRQ_MASK: readWord = toWord(mask);
      OFF_ALARM_MATCH_FLAG_0: readWord = alarmVal[0];
      OFF_ALARM_MATCH_FLAG_1: readWord = alarmVal[1];
      OFF_PERIOD0: readWord = {27'h0, perTap[0]};
      OFF_PERIOD1: readWord = {27'h0, perTap[1]};
      OFF_CLOCK: readWord = {21'h0, clkSrc, 7'h00, clkOn};
      default: readWord = WORD_RESET;
    endcase
    if (busy && syncHit)
      readWord = WORD_RESET;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      avs_readdata <= WORD_RESET;
    else if (avs_read && avs_waitrequest)
      avs_readdata <= readWord;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_clkChange;
    wrClock && (avs_writedata[CLK_ON_BIT] != clkOn);
  endsequence
  sequence s_clkSettle;
    clock_sync_pending_bit [*4] ##1 !clock_sync_pending_bit;
  endsequence

  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_prescaler_clear: assert property (wrSync && avs_address == OFF_CONTROL && avs_writedata[CTL_PRE_CLEAR_BIT]
    |=> pre == 32'h0) else $error("prescaler not cleared");
  a_count_step: assert property (tick && !clrAlarm && !ctl[CTL_CAL_BIT] && !(wrSync && avs_address == OFF_COUNT)
    |=> count == $past(count) + 32'h1) else $error("count step wrong");
  a_wrap_flag: assert property (tick && !ctl[CTL_CAL_BIT] && count == 32'hffff_ffff && !(wrSync && avs_address == OFF_COUNT)
    |=> count == 32'h0 && flags.wrap) else $error("wrap missed");
  a_clock_sync_pending_bit_cycle: assert property (s_clkChange |=> s_clkSettle ##1 flags.clock_sync_done_irq)
    else $error("clock busy sequence wrong");
  a_ready_fall: assert property ($fell(busy) |=> flags.ready) else $error("ready flag missed");
  a_busy_drops: assert property (busy && wrAcc && avs_address == OFF_CONTROL |=> $stable(ctl))
    else $error("write taken while busy");
  a_irq_masked: assert property (!mask.wrap |=> !irq.wrap) else $error("masked request raised");
  a_irq_follows: assert property (flags.alarm[0] && mask.alarm[0] |=> irq.alarm) else $error("alarm request missing");
  a_debug_freeze: assert property (freeze && !(wrSync && avs_address == OFF_CONTROL) |=> $stable(pre))
    else $error("prescaler ran in debug");

endmodule

// ---- core/atrc_pkg.sv ----
// Shared constants and types for the asynchronous timer core
package atrc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_STAT_CLEAR = 8'h0c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] OFF_IRQ_DIS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_ALARM_MATCH_FLAG_0 = 8'h20;
  localparam logic [7:0] OFF_ALARM_MATCH_FLAG_1 = 8'h24;
  localparam logic [7:0] OFF_PERIOD0 = 8'h30;
  localparam logic [7:0] OFF_PERIOD1 = 8'h34;
  localparam logic [7:0] OFF_CLOCK = 8'h40;

  // Control word fields
  localparam int CTL_RUN_BIT = 0;
  localparam int CTL_PRE_CLEAR_BIT = 1;
  localparam int CTL_CAL_BIT = 2;
  localparam int CTL_CLR_ALARM_LSB = 8;
  localparam int CTL_TAP_LSB = 16;
  localparam int TAP_W = 5;

  // Clock word fields and source codes
  localparam int CLK_ON_BIT = 0;
  localparam int CLK_SRC_LSB = 8;
  localparam int SRC_W = 3;
  localparam logic [2:0] SRC_RC = 3'h0;
  localparam logic [2:0] SRC_XTAL = 3'h1;
  localparam logic [2:0] SRC_BUS = 3'h2;
  localparam logic [2:0] SRC_GEN = 3'h3;
  localparam logic [2:0] SRC_KHZ = 3'h4;

  // Status, mask and clear word bit positions
  localparam int ST_WRAP = 0;
  localparam int ST_ALARM_LSB = 8;
  localparam int ST_PERIOD_LSB = 16;
  localparam int ST_BUSY = 24;
  localparam int ST_READY = 25;
  localparam int ST_CLK_BUSY = 28;
  localparam int ST_CLK_READY = 29;

  // Calendar layout inside the count word
  localparam int CAL_SEC_LSB = 0;
  localparam int CAL_MIN_LSB = 6;
  localparam int CAL_HOUR_LSB = 12;
  localparam int CAL_DAY_LSB = 17;
  localparam int CAL_MON_LSB = 22;
  localparam int CAL_YEAR_LSB = 26;

  // Reset values and synchronisation lengths
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [3:0] SYNC_CYCLES = 4'h3;
  localparam logic [3:0] CLK_SYNC_CYCLES = 4'h4;

  typedef struct packed {
    logic wrap;
    logic [1:0] alarm;
    logic [1:0] period;
    logic ready;
    logic clock_sync_done_irq;
  } atrc_flags_t;

  typedef struct packed {
    logic wrap;
    logic period;
    logic alarm;
    logic clock_sync_done_irq;
    logic ready;
  } atrc_irq_t;

endpackage
